// file: core/hpfc_config.sv
// Hub port feature configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hpfc_config
    import hpfc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Configuration byte port
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Configuration source
    input wire logic use_straps,
    input wire logic [1:0] fixed_port_straps,
    // Reported settings
    output logic compound_report,
    output logic port_renumber_select,
    output logic [1:0] indicator_behaviour_select,
    output logic speed_indication,
    output logic indicator_support,
    output logic string_support,
    output logic [7:0] fixed_port_mask
);
    // ****************************************
    // Strap synchroniser
    // ****************************************
    // Three stages; a change counts once stages two and three agree
    // Stage one may be metastable, so only stage two reads it
    logic [1:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
    logic src_s1_q, src_s2_q, src_s3_q, src_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
            strap_s3_q <= 2'h0;
        end else begin
            strap_s1_q <= fixed_port_straps;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
        end
    end
    // Agreement filter rejects a one-cycle glitch on a strap pin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            strap_q <= 2'h0;
        end else if (strap_s2_q == strap_s3_q) begin
            strap_q <= strap_s3_q;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            src_s1_q <= 1'b0;
            src_s2_q <= 1'b0;
            src_s3_q <= 1'b0;
        end else begin
            src_s1_q <= use_straps;
            src_s2_q <= src_s1_q;
            src_s3_q <= src_s2_q;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            src_q <= 1'b0;
        end else if (src_s2_q == src_s3_q) begin
            src_q <= src_s3_q;
        end
    end
    // ****************************************
    // Registers
    // ****************************************
    // Address match, shared by write decode and read select
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction
    logic [7:0] compound_flag_config_q, port_map_led_string_config_q, fixed_port_mask_q;
    wire hit_comp = addr_hit(cfg_addr, HPFC_OFS_COMPOUND);
    wire hit_port = addr_hit(cfg_addr, HPFC_OFS_PORTCFG);
    wire hit_mask = addr_hit(cfg_addr, HPFC_OFS_FIXMASK);
    wire hit_any = hit_comp || hit_port || hit_mask;
    wire wr_comp = cfg_wr && hit_comp;
    wire wr_port = cfg_wr && hit_port;
    wire wr_mask = cfg_wr && hit_mask;
    // Only the compound bit is kept; stored in strap mode too
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            compound_flag_config_q <= HPFC_RST_COMPOUND;
        end else if (wr_comp) begin
            compound_flag_config_q <= cfg_wdata & HPFC_MASK_COMPOUND;
        end
    end
    // Upper nibble reserved and dropped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port_map_led_string_config_q <= HPFC_RST_PORTCFG;
        end else if (wr_port) begin
            port_map_led_string_config_q <= cfg_wdata & HPFC_MASK_PORTCFG;
        end
    end
    // Bit zero never stored, so it cannot leak to the host
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fixed_port_mask_q <= HPFC_RST_FIXMASK;
        end else if (wr_mask) begin
            fixed_port_mask_q <= cfg_wdata & HPFC_MASK_FIXMASK;
        end
    end
    // ****************************************
    // Derived settings
    // ****************************************
    // Straps cover only two ports; they land on ports 1 and 2
    wire [7:0] strap_mask = {5'h00, strap_q, 1'b0};
    wire [7:0] eff_mask = src_q ? strap_mask : fixed_port_mask_q;
    wire [1:0] led_code = port_map_led_string_config_q[HPFC_BIT_LED_LO +: 2];
    wire compound_d = src_q ? (|strap_mask)
                            : compound_flag_config_q[HPFC_BIT_COMPOUND];
    // Speed code decode, shared by the mode outputs
    function automatic logic speed_code(input logic [1:0] code);
        return code == HPFC_LED_SPEED;
    endfunction
    wire is_speed = speed_code(led_code);
    // Unmapped offsets read zero
    wire [7:0] rdata_d = hit_comp ? compound_flag_config_q :
                         hit_port ? port_map_led_string_config_q :
                         hit_mask ? fixed_port_mask_q : 8'h00;
    // Read data follows the address by one edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= rdata_d;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            compound_report <= 1'b0;
        end else begin
            compound_report <= compound_d;
        end
    end
    // Indicator support resets high, as code 00 is USB mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port_renumber_select <= 1'b0;
            indicator_behaviour_select <= 2'h0;
            speed_indication <= 1'b0;
            indicator_support <= 1'b1;
            string_support <= 1'b0;
        end else begin
            port_renumber_select <= port_map_led_string_config_q[HPFC_BIT_RENUMBER];
            indicator_behaviour_select <= led_code;
            speed_indication <= is_speed;
            indicator_support <= !is_speed;
            string_support <= port_map_led_string_config_q[HPFC_BIT_STRING];
        end
    end
    // Strap mask reaches the host only after the filter settles
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fixed_port_mask <= 8'h00;
        end else begin
            fixed_port_mask <= eff_mask & HPFC_MASK_FIXMASK;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    AST_MASK_BIT0: assert property (@(posedge sys_clk) disable iff (!resetn)
        fixed_port_mask[0] == 1'b0 && (!$past(hit_mask) || cfg_rdata[0] == 1'b0))
        else $error("mask bit0 set");
    AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!resetn)
        (compound_flag_config_q & ~HPFC_MASK_COMPOUND) == 8'h00
        && (port_map_led_string_config_q & ~HPFC_MASK_PORTCFG) == 8'h00)
        else $error("reserved set");
    AST_LED_SUPPORT: assert property (@(posedge sys_clk) disable iff (!resetn)
        indicator_support == (indicator_behaviour_select != HPFC_LED_SPEED))
        else $error("indicator support wrong");
    AST_SPEED: assert property (@(posedge sys_clk) disable iff (!resetn)
        (led_code == 2'b01) |=> speed_indication) else $error("speed mode lost");
    AST_SPEED_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
        (led_code != 2'b01) |=> !speed_indication) else $error("speed mode stuck");
    AST_LED_CODE: assert property (@(posedge sys_clk) disable iff (!resetn)
        indicator_behaviour_select == $past(led_code)) else $error("led code lost");
    AST_COMPOUND: assert property (@(posedge sys_clk) disable iff (!resetn)
        !src_q && compound_flag_config_q[3] |=> compound_report)
        else $error("compound not reported");
    AST_NO_COMPOUND: assert property (@(posedge sys_clk) disable iff (!resetn)
        !src_q && !compound_flag_config_q[3] |=> !compound_report)
        else $error("compound reported");
    AST_STRAP_COMP: assert property (@(posedge sys_clk) disable iff (!resetn)
        src_q && (strap_q != 2'h0) |=> compound_report)
        else $error("strap compound missing");
    AST_STRAP_NOCOMP: assert property (@(posedge sys_clk) disable iff (!resetn)
        src_q && (strap_q == 2'h0) |=> !compound_report) else $error("strap compound extra");
    AST_STRAP_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
        src_q |=> fixed_port_mask == $past(strap_mask)) else $error("strap mask");
    AST_STRAP_SYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$stable(strap_q) |-> $past(strap_s2_q) == $past(strap_s3_q))
        else $error("strap filter bypassed");
    AST_REG_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
        !src_q |=> fixed_port_mask == $past(fixed_port_mask_q))
        else $error("register mask not reported");
    AST_RENUMBER: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_port |-> ##2 port_renumber_select == $past(cfg_wdata[3], 2))
        else $error("renumber wrong");
    AST_STRING: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_port |-> ##2 string_support == $past(cfg_wdata[0], 2))
        else $error("string wrong");
    AST_MASK_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_mask && !src_q && !src_s3_q |-> ##2 fixed_port_mask == ($past(cfg_wdata, 2) & 8'hfe))
        else $error("mask write wrong");
    AST_RD_COMP: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(hit_comp) |-> cfg_rdata == $past(compound_flag_config_q))
        else $error("compound read wrong");
    AST_RD_PORT: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(hit_port) |-> cfg_rdata == $past(port_map_led_string_config_q))
        else $error("port config read wrong");
    AST_RD_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(hit_mask) |-> cfg_rdata == $past(fixed_port_mask_q))
        else $error("mask read wrong");
    AST_UNMAPPED_RD: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(hit_any) |-> cfg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_UNMAPPED_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        cfg_wr && !hit_any |=> $stable(compound_flag_config_q)
        && $stable(port_map_led_string_config_q) && $stable(fixed_port_mask_q))
        else $error("unmapped write landed");
    // ****************************************
    // Cover points
    // ****************************************
    COV_COMPOUND: cover property (@(posedge sys_clk) disable iff (!resetn) wr_comp ##2 compound_report);
    COV_SPEED: cover property (@(posedge sys_clk) disable iff (!resetn) wr_port ##2 speed_indication);
    COV_STRAP: cover property (@(posedge sys_clk) disable iff (!resetn) src_q && compound_report);
    COV_REMAP_STRING: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_port ##2 (port_renumber_select && string_support));
    COV_UNMAPPED_WR: cover property (@(posedge sys_clk) disable iff (!resetn)
        cfg_wr && !hit_any);
endmodule
`default_nettype wire

// file: pkg/hpfc_pkg.sv
// Constants and types for the hub port feature configuration bank
// Notes on behaviour
// - Compound bit three reports compound device
// - Strap mode: any fixed port implies compound
// - Bit three picks standard or re-map numbering
// - LED code 01 speed, others USB mode
// - Indicator support reported only in USB mode
// - Bit zero enables string descriptor support
// - Mask bits 7:1 mark ports non-removable
// - Mask bit zero always reads zero
// - Internal default uses fixed-port straps instead
package hpfc_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] HPFC_OFS_COMPOUND = 8'h07;
    localparam logic [7:0] HPFC_OFS_PORTCFG = 8'h08;
    localparam logic [7:0] HPFC_OFS_FIXMASK = 8'h09;
    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int HPFC_BIT_COMPOUND = 3;
    localparam int HPFC_BIT_RENUMBER = 3;
    localparam int HPFC_BIT_LED_LO = 1;
    localparam int HPFC_BIT_STRING = 0;
    localparam logic [7:0] HPFC_MASK_COMPOUND = 8'h08;
    localparam logic [7:0] HPFC_MASK_PORTCFG = 8'h0f;
    localparam logic [7:0] HPFC_MASK_FIXMASK = 8'hfe;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] HPFC_RST_COMPOUND = 8'h00;
    localparam logic [7:0] HPFC_RST_PORTCFG = 8'h00;
    localparam logic [7:0] HPFC_RST_FIXMASK = 8'h00;
    // ****************************************
    // Indicator behaviour codes
    // ****************************************
    typedef enum logic [1:0] {
        HPFC_LED_USB = 2'b00,
        HPFC_LED_SPEED = 2'b01,
        HPFC_LED_USB_ALT1 = 2'b10,
        HPFC_LED_USB_ALT2 = 2'b11
    } hpfc_led_e;
endpackage

// file: test/hpfc_host_model.sv
// Host view of the hub descriptor fields
`timescale 1ns/1ps
`default_nettype none
module hpfc_host_model (
    // Reported settings
    input wire logic compound_report,
    input wire logic indicator_support,
    input wire logic [7:0] fixed_port_mask,
    // Descriptor content seen by the host
    output logic [15:0] hub_char,
    output logic [7:0] removable_map
);
    assign hub_char = {8'h00, indicator_support, 4'h0, compound_report, 2'b00};
    assign removable_map = fixed_port_mask;
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 0, resetn = 0, cfg_wr = 0, use_straps = 0, rd_chk = 0, st_chk = 0;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, fixed_port_mask, removable_map;
    logic [1:0] fixed_port_straps = 2'h0, indicator_behaviour_select;
    logic compound_report, port_renumber_select, speed_indication, indicator_support;
    logic string_support;
    logic [15:0] hub_char;
    logic [7:0] r7, r8, r9, rd_q[$];
    logic [14:0] st_q[$];
    logic [14:0] st_seen;
    int fails = 0, checks_done = 0;
    always #4 sys_clk = ~sys_clk;
    hpfc_config u_dut (.sys_clk, .resetn, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .use_straps, .fixed_port_straps, .compound_report, .port_renumber_select,
        .indicator_behaviour_select, .speed_indication, .indicator_support,
        .string_support, .fixed_port_mask);
    hpfc_host_model u_host (.compound_report, .indicator_support, .fixed_port_mask,
        .hub_char, .removable_map);
    // Settings as the host and the pins present them, in exp_st order
    assign st_seen = {hub_char[2], port_renumber_select, indicator_behaviour_select,
        speed_indication, hub_char[7], string_support, removable_map};
    task automatic final_report;
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected cfg_rdata expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_st(input logic [14:0] e, input logic [14:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected settings expected %h seen %h", e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 cfg_wr = 1;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge sys_clk);
        #1 cfg_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        #1 cfg_addr = a;
        @(posedge sys_clk);
        #1 rd_q.push_back(e);
        rd_chk = 1;
        @(posedge sys_clk);
        #1 rd_chk = 0;
    endtask
    // Eight edges also cover the strap synchroniser delay
    task automatic st(input logic [14:0] e);
        repeat (8) @(posedge sys_clk);
        #1 st_q.push_back(e);
        st_chk = 1;
        @(posedge sys_clk);
        #1 st_chk = 0;
    endtask
    function automatic logic [14:0] exp_st(input logic us, input logic [1:0] s);
        logic [7:0] m;
        m = us ? {5'h00, s, 1'b0} : r9;
        return {us ? |s : r7[3], r8[3], r8[2:1], r8[2:1] == 2'b01, r8[2:1] != 2'b01,
            r8[0], m};
    endfunction
    always @(negedge sys_clk) begin
        if (rd_chk === 1'b1) cmp_rd(rd_q.pop_front(), cfg_rdata);
        if (st_chk === 1'b1) cmp_st(st_q.pop_front(), st_seen);
    end
    initial begin
        logic [7:0] d7, d8, d9, ua;
        void'($urandom(97));
        r7 = 8'h00;
        r8 = 8'h00;
        r9 = 8'h00;
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1;
        st(exp_st(1'b0, 2'h0));
        for (int i = 0; i < 40; i++) begin
            d7 = 8'($urandom);
            d8 = 8'($urandom);
            d9 = 8'($urandom);
            ua = 8'h0a + 8'($urandom % 240);
            d8[2:1] = i[1:0];
            d9[1] = d9[1] | d7[3];
            wr(8'h07, d7);
            wr(8'h08, d8);
            wr(8'h09, d9);
            wr(ua, 8'($urandom));
            use_straps = 1'($urandom);
            fixed_port_straps = 2'($urandom);
            r7 = d7 & hpfc_pkg::HPFC_MASK_COMPOUND;
            r8 = d8 & hpfc_pkg::HPFC_MASK_PORTCFG;
            r9 = d9 & hpfc_pkg::HPFC_MASK_FIXMASK;
            st(exp_st(use_straps, fixed_port_straps));
            rd(8'h07, r7);
            rd(8'h08, r8);
            rd(8'h09, r9);
            rd(ua, 8'h00);
        end
        // Mid-run reset must bring every setting back to its reset value
        use_straps = 0;
        @(posedge sys_clk);
        #1 resetn = 0;
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1;
        r7 = 8'h00;
        r8 = 8'h00;
        r9 = 8'h00;
        st(exp_st(1'b0, fixed_port_straps));
        rd(8'h07, r7);
        rd(8'h08, r8);
        rd(8'h09, r9);
        final_report();
    end
    initial begin
        #200000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
